// >>> design/pcs_client.v
// pcs client side: byte/nibble receive path, tx capture and speed status
`timescale 1ns/1ps
`include "pcs_client_regs.vh"
module pcs_client (
    input wire sys_clk,
    input wire rst_n,
    input wire sgmii_mode,
    input wire autoneg_use_bit,
    input wire [1:0] forced_speed,
    input wire forced_duplex,
    input wire [15:0] partner_ability,
    input wire byte_tx_en,
    input wire [7:0] byte_tx_data,
    input wire byte_tx_err,
    input wire nibble_tx_en,
    input wire [3:0] nibble_tx_data,
    input wire nibble_tx_err,
    output reg line_tx_valid,
    output reg [7:0] line_tx_data,
    output reg line_tx_err,
    input wire line_rx_valid,
    input wire [7:0] line_rx_data,
    input wire line_rx_err,
    output wire line_rx_ready,
    input wire line_collision,
    output reg [7:0] byte_rx_data,
    output reg byte_rx_valid,
    output reg byte_rx_err,
    output reg [3:0] nibble_rx_data,
    output reg nibble_rx_valid,
    output reg nibble_rx_err,
    output reg nibble_col,
    output reg nibble_crs,
    output reg rx_clk_ena,
    output reg tx_clk_ena,
    output reg gigabit_flag,
    output reg fast_flag,
    output reg slow_flag,
    output reg half_duplex_flag
);
    reg [1:0] spd;
    reg hd;
    reg [7:0] div_r;
    reg [7:0] div_max;
    reg ena_r;
    reg nib_hi_r;
    reg [3:0] tx_lo_r;
    reg tx_half_r;
    reg sync_col_a_r;
    reg sync_col_r;
    wire buf_valid;
    wire [8:0] buf_word;
    wire gig_now = (spd == `SPEED_1000);
    wire pop = buf_valid && ena_r && (gig_now || nib_hi_r);
    // speed and duplex decode
    always @* begin
        if (!sgmii_mode) begin
            spd = `SPEED_1000;
            hd = 1'b0;
        end else if (autoneg_use_bit) begin
            spd = partner_ability[`ABIL_SPEED_LSB +: 2];
            hd = ~partner_ability[`ABIL_DUPLEX_BIT];
        end else begin
            spd = forced_speed;
            hd = forced_duplex;
        end
        case (spd)
            `SPEED_100: div_max = `DIV_100 - 8'h01;
            `SPEED_10: div_max = `DIV_10 - 8'h01;
            default: div_max = `DIV_1000 - 8'h01;
        endcase
    end
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_col_a_r <= 1'b0;
            sync_col_r <= 1'b0;
        end else begin
            sync_col_a_r <= line_collision;
            sync_col_r <= sync_col_a_r;
        end
    end
    word_buffer #(.WIDTH(9)) rx_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(line_rx_valid),
        .in_ready(line_rx_ready),
        .in_data({line_rx_err, line_rx_data}),
        .out_valid(buf_valid),
        .out_ready(pop),
        .out_data(buf_word)
    );
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
            ena_r <= 1'b0;
            nib_hi_r <= 1'b0;
            tx_half_r <= 1'b0;
            tx_lo_r <= 4'h0;
            rx_clk_ena <= 1'b0;
            tx_clk_ena <= 1'b0;
            byte_rx_data <= 8'h00;
            byte_rx_valid <= 1'b0;
            byte_rx_err <= 1'b0;
            nibble_rx_data <= 4'h0;
            nibble_rx_valid <= 1'b0;
            nibble_rx_err <= 1'b0;
            nibble_col <= 1'b0;
            nibble_crs <= 1'b0;
            line_tx_valid <= 1'b0;
            line_tx_data <= 8'h00;
            line_tx_err <= 1'b0;
            gigabit_flag <= 1'b1;
            fast_flag <= 1'b0;
            slow_flag <= 1'b0;
            half_duplex_flag <= 1'b0;
        end else begin
            // 125 mhz client rate, slower in sgmii 10/100
            if (div_r >= div_max) begin
                div_r <= 8'h00;
                ena_r <= 1'b1;
            end else begin
                div_r <= div_r + 8'h01;
                ena_r <= 1'b0;
            end
            rx_clk_ena <= (div_r >= div_max) && sgmii_mode;
            tx_clk_ena <= (div_r >= div_max) && sgmii_mode;
            gigabit_flag <= gig_now;
            fast_flag <= (spd == `SPEED_100);
            slow_flag <= (spd == `SPEED_10);
            half_duplex_flag <= hd;
            line_tx_valid <= 1'b0;
            if (ena_r) begin
                // receive: byte per enable at gigabit, nibble pairs otherwise
                byte_rx_valid <= gig_now && buf_valid;
                byte_rx_err <= gig_now && buf_valid && buf_word[8];
                if (gig_now && buf_valid) begin
                    byte_rx_data <= buf_word[7:0];
                end
                nibble_rx_valid <= !gig_now && buf_valid;
                nibble_rx_err <= !gig_now && buf_valid && buf_word[8];
                if (!gig_now && buf_valid) begin
                    nibble_rx_data <= nib_hi_r ? buf_word[7:4] : buf_word[3:0];
                    nib_hi_r <= ~nib_hi_r;
                end else begin
                    nib_hi_r <= 1'b0;
                end
                // transmit: client keeps enable to valid cycles
                if (gig_now) begin
                    line_tx_valid <= byte_tx_en;
                    line_tx_data <= byte_tx_data;
                    line_tx_err <= byte_tx_err;
                    tx_half_r <= 1'b0;
                end else if (nibble_tx_en) begin
                    if (tx_half_r) begin
                        line_tx_valid <= 1'b1;
                        line_tx_data <= {nibble_tx_data, tx_lo_r};
                        line_tx_err <= nibble_tx_err;
                    end else begin
                        tx_lo_r <= nibble_tx_data;
                    end
                    tx_half_r <= ~tx_half_r;
                end else begin
                    tx_half_r <= 1'b0;
                end
                nibble_col <= !gig_now && nibble_tx_en && sync_col_r;
                nibble_crs <= !gig_now && (nibble_tx_en || buf_valid);
            end
        end
    end
endmodule

// >>> design/pcs_client_regs.vh
// constants for the pcs client byte/nibble interface and speed status
// How it works
// - receive valid held from first preamble byte to last check byte
// - receive error raised while the received frame is known bad
// - nibble interface raises collision on collision during transmission
// - nibble interface raises carrier sense on any transmit or receive activity
// - gigabit flag: always in 1000base-x; sgmii from autoneg or forced speed 10
// - 100 flag: zero in 1000base-x; sgmii from autoneg or forced speed 01
// - 10 flag: zero in 1000base-x; sgmii from autoneg or forced speed 00
// - half duplex: zero in 1000base-x; sgmii from autoneg or forced duplex bit
// - standalone, speed and duplex outputs steer the attached mac
// - client rate 125 mhz at gigabit, slower in sgmii 10/100, set by enables divided from sys_clk
// - sgmii clock enables qualify transfers; transfers only in enabled cycles
`ifndef PCS_CLIENT_REGS_VH
`define PCS_CLIENT_REGS_VH
`define SPEED_1000 2'h2
`define SPEED_100 2'h1
`define SPEED_10 2'h0
`define ABIL_SPEED_LSB 10
`define ABIL_DUPLEX_BIT 12
`define CLK_MHZ 250
`define CLIENT_MHZ 125
// enable spacing in system clocks: 2 at gigabit, 20 at 100, 200 at 10
`define DIV_100 8'h14
`define DIV_10 8'hC8
`define DIV_1000 8'h02
`endif

// >>> design/word_buffer.v
// two-entry valid/ready buffer
`timescale 1ns/1ps
module word_buffer #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg wr_ptr_r;
    reg rd_ptr_r;
    reg [1:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];
    always @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule

// >>> dv/mac_model.sv
// mac model driving the gigabit transmit bus
`timescale 1ns/1ps
module mac_model (
    input wire sys_clk,
    output reg tx_en = 1'b0,
    output reg [7:0] tx_data = 8'h00,
    output reg tx_err = 1'b0
);
    // a byte is held two clocks so one sampling edge sees it
    task send(input en, input [7:0] d, input e);
        tx_en <= en;
        tx_data <= en ? d : ~tx_data;
        tx_err <= e;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

// >>> dv/pcs_client_sva.sv
// checker for pcs_client speed status flags and enables
`timescale 1ns/1ps
module pcs_client_sva (
    input wire sys_clk,
    input wire rst_n,
    input wire sgmii_mode,
    input wire autoneg_use_bit,
    input wire [1:0] forced_speed,
    input wire forced_duplex,
    input wire [15:0] partner_ability,
    input wire rx_clk_ena,
    input wire tx_clk_ena,
    input wire nibble_col,
    input wire gigabit_flag,
    input wire fast_flag,
    input wire slow_flag,
    input wire half_duplex_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire an = sgmii_mode && autoneg_use_bit;
    wire fc = sgmii_mode && !autoneg_use_bit;
    wire [1:0] pc = partner_ability[11:10];
    wire [2:0] spd = {gigabit_flag, fast_flag, slow_flag};
    wire [2:0] fd = {forced_speed == 2'h2, forced_speed == 2'h1, forced_speed == 2'h0};
    wire [2:0] ad = {pc == 2'h2, pc == 2'h1, pc == 2'h0};
    a_basex_speed: assert property (!sgmii_mode |=> spd == 3'h4)
        else $error("basex speed");
    a_basex_duplex: assert property (!sgmii_mode |=> !half_duplex_flag)
        else $error("basex duplex");
    a_forced_speed: assert property (fc |=> spd == $past(fd))
        else $error("forced speed");
    a_forced_duplex: assert property (fc |=> half_duplex_flag == $past(forced_duplex))
        else $error("forced duplex");
    a_an_speed: assert property (an |=> spd == $past(ad))
        else $error("autoneg speed");
    a_an_duplex: assert property (an |=> half_duplex_flag != $past(partner_ability[12]))
        else $error("autoneg duplex");
    a_speed_onehot: assert property ($onehot0(spd))
        else $error("speed flags");
    a_ena_sgmii_only: assert property (!sgmii_mode [*2] |-> !rx_clk_ena)
        else $error("enable outside sgmii");
    a_tx_ena_pair: assert property (tx_clk_ena == rx_clk_ena)
        else $error("tx enable differs from rx enable");
    a_col_nibble_only: assert property (nibble_col |-> !gigabit_flag)
        else $error("collision at gigabit");
endmodule
bind pcs_client pcs_client_sva pcs_client_sva_inst (.*);

// >>> dv/tb.sv
// bench for pcs_client
`timescale 1ns/1ps
module tb;
    reg sys_clk = 0, rst_n = 0, sgmii_mode = 0, autoneg_use_bit = 0, forced_duplex = 0;
    reg line_rx_valid = 0, line_rx_err = 0, full_r = 0, ok, bv_r, nv_r;
    reg [1:0] forced_speed = 0;
    reg nibble_tx_en = 0, nibble_tx_err = 0, line_collision = 0;
    reg [3:0] nibble_tx_data = 0;
    wire nibble_col, nibble_crs, tx_clk_ena;
    reg [15:0] partner_ability = 0;
    reg [7:0] line_rx_data = 0, bd_r;
    reg [3:0] nd_r;
    reg [31:0] sd = 32'h491D21ED;
    wire byte_tx_en, byte_tx_err, line_tx_valid, line_tx_err, line_rx_ready, byte_rx_valid;
    wire byte_rx_err, nibble_rx_valid, nibble_rx_err, rx_clk_ena, gigabit_flag, fast_flag;
    wire slow_flag, half_duplex_flag;
    wire [7:0] byte_tx_data, line_tx_data, byte_rx_data;
    wire [3:0] nibble_rx_data;
    logic [8:0] tq[$], bq[$], nq[$];
    integer error_cnt = 0, n_tests = 0, k, m;
    pcs_client pcs_client_inst (.*);
    mac_model mac_model_inst (.sys_clk, .tx_en(byte_tx_en), .tx_data(byte_tx_data),
        .tx_err(byte_tx_err));
    initial forever #2 sys_clk = ~sys_clk;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cmp(input string nm, input [8:0] e, input [8:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task results;
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // nibble held for one full 100 Mbps enable period
    task nib_send(input [3:0] d, input e);
        nibble_tx_en <= 1'b1;
        nibble_tx_data <= d;
        nibble_tx_err <= e;
        repeat (20) @(posedge sys_clk);
    endtask
    // word held until an edge sees ready high
    task rx_word(input [7:0] d, input e);
        if (m == 0) bq.push_back({e, d});
        else begin
            nq.push_back({e, 4'h0, d[3:0]});
            nq.push_back({e, 4'h0, d[7:4]});
        end
        line_rx_valid <= 1'b1;
        line_rx_data <= d;
        line_rx_err <= e;
        do begin
            @(negedge sys_clk);
            ok = line_rx_ready;
            full_r |= !ok;
            @(posedge sys_clk);
        end while (ok !== 1'b1);
    endtask
    always @(posedge sys_clk) begin
        if (line_tx_valid === 1'b1) cmp("tx", tq.pop_front(), {line_tx_err, line_tx_data});
        if (byte_rx_valid === 1'b1 && (!bv_r || byte_rx_data !== bd_r))
            cmp("byte_rx", bq.pop_front(), {byte_rx_err, byte_rx_data});
        if (nibble_rx_valid === 1'b1 && (!nv_r || nibble_rx_data !== nd_r))
            cmp("nib_rx", nq.pop_front(), {nibble_rx_err, 4'h0, nibble_rx_data});
        {bv_r, bd_r, nv_r, nd_r} <= {byte_rx_valid, byte_rx_data, nibble_rx_valid, nibble_rx_data};
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        results;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        for (k = 0; k < 32; k++) begin
            sd = lfsr(sd);
            {sgmii_mode, autoneg_use_bit, forced_duplex, forced_speed} <= k[4:0];
            partner_ability <= (sd[15:0] & 16'hE3FF) | {3'h0, k[2:0], 10'h0};
            repeat (2) @(posedge sys_clk);
        end
        sgmii_mode <= 1'b0;
        for (k = 0; k < 9; k++) begin
            sd = lfsr(sd);
            if (k < 8) tq.push_back({k == 7, sd[7:0]});
            mac_model_inst.send(k < 8, sd[7:0], k == 7);
        end
        for (m = 0; m < 3; m++) begin
            sgmii_mode <= m != 0;
            autoneg_use_bit <= 1'b0;
            forced_speed <= m[0] ? 2'h1 : 2'h0;
            repeat (4) @(posedge sys_clk);
            for (k = 0; k < 8; k++) rx_word({k[2:0], 1'b1, k[2:0], 1'b0}, k == 7);
            line_rx_valid <= 1'b0;
            line_rx_data <= ~line_rx_data;
            while (bq.size() + nq.size() != 0) @(posedge sys_clk);
            if (m == 1) begin
                line_collision <= 1'b1;
                for (k = 0; k < 4; k++) begin
                    sd = lfsr(sd);
                    tq.push_back({k == 3, sd[7:0]});
                    nib_send(sd[3:0], k == 3);
                    nib_send(sd[7:4], k == 3);
                end
                @(negedge sys_clk);
                cmp("col", 9'h1, {8'h0, nibble_col});
                cmp("crs", 9'h1, {8'h0, nibble_crs});
                @(posedge sys_clk);
                nibble_tx_en <= 1'b0;
                line_collision <= 1'b0;
                repeat (44) @(posedge sys_clk);
                @(negedge sys_clk);
                cmp("col_idle", 9'h0, {8'h0, nibble_col});
                cmp("crs_idle", 9'h0, {8'h0, nibble_crs});
                cmp("tx_left", 9'h0, tq.size());
                @(posedge sys_clk);
            end
        end
        cmp("refused", 9'h1, {8'h0, full_r});
        results;
    end
endmodule
